// ===== src/bridge_diag_defines.svh
// Offsets, field positions, reset values and threshold figures for the diagnostic register
`ifndef BRIDGE_DIAG_DEFINES_SVH
`define BRIDGE_DIAG_DEFINES_SVH

`define DIAG0_OFFSET        8'hC0
`define DIAG0_RESET         32'h0000_0000
`define BUS_MSB             31
`define BUS_LSB             24
`define DEV_MSB             23
`define DEV_LSB             19
`define ALT_ERR_BIT         18
`define WAKE_IN_DIS_BIT     17
`define WAKE_PIN_DIS_BIT    16
`define FIFO_MSB            15
`define FIFO_LSB            14
`define ANY_FN_BIT          11
`define PW_CREDIT_BIT       10
`define CPL_CREDIT_BIT      8
`define LINE_CHECK_BIT      7
`define QUAD_PREFETCH_BIT   6
`define THRESH_MSB          5
`define THRESH_LSB          4
`define THRESH_CTRL_BIT     3
`define MEM_CFG_BIT         2
`define RSVD_RW_BIT         1
`define RSVD_HI_MSB         13
`define RSVD_HI_LSB         12
`define RSVD_MID_BIT        9
`define RSVD_LO_BIT         0
`define DEFAULT_LINE_DW     8'h08
`define THRESH_EXTRA_4      8'h04
`define THRESH_EXTRA_8      8'h08
`define THRESH_EXTRA_12     8'h0C
`define PREFETCH_ONE_DW     2'h0
`define PREFETCH_TWO_LINES  2'h1
`define PREFETCH_FOUR_LINES 2'h2

`endif

// ===== src/bridge_diag_pkg.sv
// Types shared by the bridge control and diagnostic register
package bridge_diag_pkg;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  offset;
        logic [3:0]  byte_en;
        logic [31:0] wdata;
    } cfg_req_t;

    typedef struct packed {
        logic [7:0] bus;
        logic [4:0] device;
        logic       valid;
    } capture_t;

    typedef enum logic [1:0] {
        PF_ONE_DW,
        PF_TWO_LINES,
        PF_FOUR_LINES
    } prefetch_t;

endpackage

// ===== src/bridge_control_diag_reg0.sv
// Control and diagnostic register zero of the bridge with its steering outputs
`timescale 1ns/10ps
`include "bridge_diag_defines.svh"

// Function
// - Bits 31:24 read back the captured upstream bus number, read-only.
// - Bits 23:19 read back the captured upstream device number, read-only.
// - Bit 18 set means advisory nonfatal error reporting unsupported.
// - Bit 17 clear routes controller wake event into bridge; set blocks it.
// - Bit 16 clear lets controller wake pin follow event; set disables pin.
// - Bits 17 and 16 clear only on global or power-on reset.
// - Other writable fields clear whenever fundamental reset is low.
// - Bits 15:14 hold the FIFO maximum size in doublewords.
// - Bit 11 set lets bridge answer configuration to any function number.
// - Bit 10 set returns all posted-write flow-control credits.
// - Bit 8 set returns all completion credits immediately.
// - Bit 7 picks transaction size from side-band or cache line size.
// - Bit 6 picks two or four cache lines for read-multiple prefetch.
// - Bit 6 with force-read-multiple extends four lines to plain reads.
// - Read prefetch disable overrides bit 6; burst reads fetch one doubleword.
// - Bit 6 acts only while bit 7 is set.
// - Bits 5:4 pick line plus 4, 8, 12 DW, or two lines plus 4.
// - A PCI transaction is accepted only with threshold space free when bit 3 is set, else with any free space.
// - Invalid cache line size counts as eight doublewords for threshold.
// - Bit 3 enables the upstream request buffer threshold mode.
// - Bit 2 set lets configuration reach memory-mapped configuration registers.
// - Reserved bits 13:12, 9 and 0 always read zero.
// - Register sits at offset C0h and resets to all zeros.
module bridge_control_diag_reg0 (
    // Clock and resets
    input  wire logic                     mclk,
    input  wire logic                     rst,
    input  wire logic                     global_reset_n,
    input  wire logic                     fundamental_reset_n,
    // Configuration access
    input  wire bridge_diag_pkg::cfg_req_t cfg_req,
    output logic                          cfg_ack,
    output logic [31:0]                   cfg_rdata,
    // Captured identity
    input  wire bridge_diag_pkg::capture_t capture,
    // Wake event paths
    input  wire logic                     power_event_signal,
    output logic                          bridge_wake_input,
    output logic                          controller_wake_pin,
    // Upstream read context
    input  wire logic                     force_read_multiple,
    input  wire logic                     read_prefetch_disable,
    input  wire logic                     memory_read_multiple,
    input  wire logic [7:0]               cache_line_size,
    input  wire logic                     cache_line_valid,
    input  wire logic [7:0]               free_buffer_dw,
    input  wire logic                     pci_request,
    // Steering outputs
    output logic                          alternate_error_method,
    output logic [1:0]                    fifo_size,
    output logic                          config_any_function_enable,
    output logic                          posted_write_credit_return,
    output logic                          completion_credit_return,
    output logic                          use_cache_line_size,
    output bridge_diag_pkg::prefetch_t    prefetch_depth,
    output logic                          threshold_mode,
    output logic                          pci_accept,
    output logic                          config_mem_access_enable
);

    ////////////////////////////////////////////////////////////////////////////
    // Register state

    logic [31:0] diag;
    logic [31:0] next_diag;
    logic [31:0] wmask;
    logic        hit;
    logic        do_write;

    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wmask[b*8 +: 8] = {8{cfg_req.byte_en[b]}};
        end
        hit      = cfg_req.valid && (cfg_req.offset == `DIAG0_OFFSET);
        do_write = hit && cfg_req.write;
    end

    // Writable fields clear by fundamental reset; wake bits need global reset
    always_comb begin
        next_diag = diag;
        if (capture.valid) begin
            next_diag[`BUS_MSB:`BUS_LSB] = capture.bus;
            next_diag[`DEV_MSB:`DEV_LSB] = capture.device;
        end
        if (do_write) begin
            // Only writable fields follow the write, read-only ones keep value
            next_diag[`ALT_ERR_BIT] = wmask[`ALT_ERR_BIT]
                ? cfg_req.wdata[`ALT_ERR_BIT] : diag[`ALT_ERR_BIT];
            next_diag[`WAKE_IN_DIS_BIT] = wmask[`WAKE_IN_DIS_BIT]
                ? cfg_req.wdata[`WAKE_IN_DIS_BIT] : diag[`WAKE_IN_DIS_BIT];
            next_diag[`WAKE_PIN_DIS_BIT] = wmask[`WAKE_PIN_DIS_BIT]
                ? cfg_req.wdata[`WAKE_PIN_DIS_BIT] : diag[`WAKE_PIN_DIS_BIT];
            next_diag[`FIFO_MSB:`FIFO_LSB] =
                (cfg_req.wdata[`FIFO_MSB:`FIFO_LSB] & wmask[`FIFO_MSB:`FIFO_LSB])
                | (diag[`FIFO_MSB:`FIFO_LSB] & ~wmask[`FIFO_MSB:`FIFO_LSB]);
            next_diag[`ANY_FN_BIT:`PW_CREDIT_BIT] =
                (cfg_req.wdata[`ANY_FN_BIT:`PW_CREDIT_BIT]
                 & wmask[`ANY_FN_BIT:`PW_CREDIT_BIT])
                | (diag[`ANY_FN_BIT:`PW_CREDIT_BIT]
                   & ~wmask[`ANY_FN_BIT:`PW_CREDIT_BIT]);
            next_diag[`CPL_CREDIT_BIT:`RSVD_RW_BIT] =
                (cfg_req.wdata[`CPL_CREDIT_BIT:`RSVD_RW_BIT]
                 & wmask[`CPL_CREDIT_BIT:`RSVD_RW_BIT])
                | (diag[`CPL_CREDIT_BIT:`RSVD_RW_BIT]
                   & ~wmask[`CPL_CREDIT_BIT:`RSVD_RW_BIT]);
        end
        next_diag[`RSVD_HI_MSB:`RSVD_HI_LSB] = 2'h0;
        next_diag[`RSVD_MID_BIT]             = 1'h0;
        next_diag[`RSVD_LO_BIT]              = 1'h0;
        // Reset priorities: fundamental clears all but wake bits
        if (!fundamental_reset_n) begin
            next_diag[`BUS_MSB:`WAKE_IN_DIS_BIT+1] = '0;
            next_diag[`FIFO_MSB:0]                 = '0;
        end
        if (!global_reset_n) begin
            next_diag[`WAKE_IN_DIS_BIT]  = 1'h0;
            next_diag[`WAKE_PIN_DIS_BIT] = 1'h0;
        end
    end

    // rst stands for the internal power-on reset, clearing everything but prefetch_depth, which loads PF_TWO_LINES
    always_ff @(posedge mclk) begin
        if (rst) begin
            diag <= `DIAG0_RESET;
        end else begin
            diag <= next_diag;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read answer

    logic        next_ack;
    logic [31:0] next_rdata;

    always_comb begin
        next_ack   = cfg_req.valid;
        next_rdata = 32'h0000_0000;
        if (hit && !cfg_req.write) begin
            next_rdata = diag;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cfg_ack   <= 1'h0;
            cfg_rdata <= 32'h0000_0000;
        end else begin
            cfg_ack   <= next_ack;
            cfg_rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Steering

    logic [7:0]                 line_dw;
    logic [7:0]                 need_dw;
    bridge_diag_pkg::prefetch_t next_prefetch;
    logic                       next_accept;

    always_comb begin
        line_dw = cache_line_valid ? cache_line_size : `DEFAULT_LINE_DW;
        case (diag[`THRESH_MSB:`THRESH_LSB])
            2'h0:    need_dw = 8'(line_dw + `THRESH_EXTRA_4);
            2'h1:    need_dw = 8'(line_dw + `THRESH_EXTRA_8);
            2'h2:    need_dw = 8'(line_dw + `THRESH_EXTRA_12);
            default: need_dw = 8'((line_dw << 1) + `THRESH_EXTRA_4);
        endcase
        // Without threshold mode a request only needs any free space
        next_accept = pci_request
            && (diag[`THRESH_CTRL_BIT] ? (free_buffer_dw >= need_dw)
                                       : (free_buffer_dw != 8'h00));
        if (read_prefetch_disable) begin
            next_prefetch = bridge_diag_pkg::PF_ONE_DW;
        end else if (diag[`LINE_CHECK_BIT] && diag[`QUAD_PREFETCH_BIT]
                     && (memory_read_multiple || force_read_multiple)) begin
            next_prefetch = bridge_diag_pkg::PF_FOUR_LINES;
        end else begin
            next_prefetch = bridge_diag_pkg::PF_TWO_LINES;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            bridge_wake_input          <= 1'h0;
            controller_wake_pin        <= 1'h0;
            alternate_error_method     <= 1'h0;
            fifo_size                  <= 2'h0;
            config_any_function_enable <= 1'h0;
            posted_write_credit_return <= 1'h0;
            completion_credit_return   <= 1'h0;
            use_cache_line_size        <= 1'h0;
            prefetch_depth             <= bridge_diag_pkg::PF_TWO_LINES;
            threshold_mode             <= 1'h0;
            pci_accept                 <= 1'h0;
            config_mem_access_enable   <= 1'h0;
        end else begin
            bridge_wake_input   <= power_event_signal && !diag[`WAKE_IN_DIS_BIT];
            controller_wake_pin <= power_event_signal && !diag[`WAKE_PIN_DIS_BIT];
            alternate_error_method     <= diag[`ALT_ERR_BIT];
            fifo_size                  <= diag[`FIFO_MSB:`FIFO_LSB];
            config_any_function_enable <= diag[`ANY_FN_BIT];
            posted_write_credit_return <= diag[`PW_CREDIT_BIT];
            completion_credit_return   <= diag[`CPL_CREDIT_BIT];
            use_cache_line_size        <= diag[`LINE_CHECK_BIT];
            prefetch_depth             <= next_prefetch;
            threshold_mode             <= diag[`THRESH_CTRL_BIT];
            pci_accept                 <= next_accept;
            config_mem_access_enable   <= diag[`MEM_CFG_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    property p_rsvd_zero;
        @(posedge mclk) disable iff (rst)
        cfg_ack |-> (cfg_rdata[`RSVD_HI_MSB:`RSVD_HI_LSB] == 2'h0
                     && !cfg_rdata[`RSVD_MID_BIT] && !cfg_rdata[`RSVD_LO_BIT]);
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit nonzero");

    property p_wake_pin;
        @(posedge mclk) disable iff (rst)
        diag[`WAKE_PIN_DIS_BIT] |=> !controller_wake_pin;
    endproperty
    a_wake_pin: assert property (p_wake_pin) else $error("wake pin not gated");

    property p_wake_in;
        @(posedge mclk) disable iff (rst)
        (!diag[`WAKE_IN_DIS_BIT] && power_event_signal) |=> bridge_wake_input;
    endproperty
    a_wake_in: assert property (p_wake_in) else $error("wake input not routed");

    property p_fundamental_reset_n_keeps_wake;
        @(posedge mclk) disable iff (rst)
        (!fundamental_reset_n && global_reset_n && !do_write)
            |=> diag[`WAKE_IN_DIS_BIT:`WAKE_PIN_DIS_BIT]
                == $past(diag[`WAKE_IN_DIS_BIT:`WAKE_PIN_DIS_BIT]);
    endproperty
    a_fundamental_reset_n_keeps_wake: assert property (p_fundamental_reset_n_keeps_wake) else $error("wake bit lost");

    property p_fundamental_reset_n_clears;
        @(posedge mclk) disable iff (rst)
        !fundamental_reset_n |=> diag[`FIFO_MSB:0] == 16'h0000;
    endproperty
    a_fundamental_reset_n_clears: assert property (p_fundamental_reset_n_clears) else $error("field not cleared");

    property p_prefetch_off;
        @(posedge mclk) disable iff (rst)
        read_prefetch_disable |=> prefetch_depth == bridge_diag_pkg::PF_ONE_DW;
    endproperty
    a_prefetch_off: assert property (p_prefetch_off) else $error("prefetch not off");

    property p_quad_gated;
        @(posedge mclk) disable iff (rst)
        !diag[`LINE_CHECK_BIT] |=> prefetch_depth != bridge_diag_pkg::PF_FOUR_LINES;
    endproperty
    a_quad_gated: assert property (p_quad_gated) else $error("quad without line check");

    property p_accept_space;
        @(posedge mclk) disable iff (rst)
        (diag[`THRESH_CTRL_BIT] && free_buffer_dw < need_dw) |=> !pci_accept;
    endproperty
    a_accept_space: assert property (p_accept_space) else $error("accepted short space");

    property p_ro_write;
        @(posedge mclk) disable iff (rst)
        (do_write && !capture.valid && fundamental_reset_n)
            |=> diag[`BUS_MSB:`DEV_LSB] == $past(diag[`BUS_MSB:`DEV_LSB]);
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("read-only field written");

    property p_capture_bus;
        @(posedge mclk) disable iff (rst)
        (capture.valid && fundamental_reset_n)
            |=> diag[`BUS_MSB:`BUS_LSB] == $past(capture.bus);
    endproperty
    a_capture_bus: assert property (p_capture_bus) else $error("bus not captured");

    property p_capture_dev;
        @(posedge mclk) disable iff (rst)
        (capture.valid && fundamental_reset_n)
            |=> diag[`DEV_MSB:`DEV_LSB] == $past(capture.device);
    endproperty
    a_capture_dev: assert property (p_capture_dev) else $error("device not captured");

    property p_alt_err;
        @(posedge mclk) disable iff (rst)
        !$past(rst) |-> alternate_error_method == $past(diag[`ALT_ERR_BIT]);
    endproperty
    a_alt_err: assert property (p_alt_err) else $error("error method not copied");

    property p_fifo;
        @(posedge mclk) disable iff (rst)
        !$past(rst) |-> fifo_size == $past(diag[`FIFO_MSB:`FIFO_LSB]);
    endproperty
    a_fifo: assert property (p_fifo) else $error("fifo size not copied");

    property p_any_fn;
        @(posedge mclk) disable iff (rst)
        !$past(rst) |-> config_any_function_enable == $past(diag[`ANY_FN_BIT]);
    endproperty
    a_any_fn: assert property (p_any_fn) else $error("any function not copied");

    property p_pw_credit;
        @(posedge mclk) disable iff (rst)
        !$past(rst) |-> posted_write_credit_return == $past(diag[`PW_CREDIT_BIT]);
    endproperty
    a_pw_credit: assert property (p_pw_credit) else $error("posted credit not copied");

    property p_cpl_credit;
        @(posedge mclk) disable iff (rst)
        !$past(rst) |-> completion_credit_return == $past(diag[`CPL_CREDIT_BIT]);
    endproperty
    a_cpl_credit: assert property (p_cpl_credit) else $error("cpl credit not copied");

    property p_line_check;
        @(posedge mclk) disable iff (rst)
        !$past(rst) |-> use_cache_line_size == $past(diag[`LINE_CHECK_BIT]);
    endproperty
    a_line_check: assert property (p_line_check) else $error("line check not copied");

    property p_thresh_mode;
        @(posedge mclk) disable iff (rst)
        !$past(rst) |-> threshold_mode == $past(diag[`THRESH_CTRL_BIT]);
    endproperty
    a_thresh_mode: assert property (p_thresh_mode) else $error("mode not copied");

    property p_mem_cfg;
        @(posedge mclk) disable iff (rst)
        !$past(rst) |-> config_mem_access_enable == $past(diag[`MEM_CFG_BIT]);
    endproperty
    a_mem_cfg: assert property (p_mem_cfg) else $error("mem access not copied");

    property p_quad_on;
        @(posedge mclk) disable iff (rst)
        (diag[`LINE_CHECK_BIT] && diag[`QUAD_PREFETCH_BIT] && force_read_multiple
         && !read_prefetch_disable) |=> prefetch_depth == bridge_diag_pkg::PF_FOUR_LINES;
    endproperty
    a_quad_on: assert property (p_quad_on) else $error("forced quad missing");

    property p_read_hit;
        @(posedge mclk) disable iff (rst)
        (hit && !cfg_req.write) |=> cfg_ack && cfg_rdata == $past(diag);
    endproperty
    a_read_hit: assert property (p_read_hit) else $error("read data wrong");

    property p_miss;
        @(posedge mclk) disable iff (rst)
        (cfg_req.valid && !hit) |=> cfg_ack && cfg_rdata == 32'h0000_0000;
    endproperty
    a_miss: assert property (p_miss) else $error("other offset aliased");

endmodule // bridge_control_diag_reg0

// ===== tb/host_cfg_model.sv
// Host model issuing configuration accesses to the register
`timescale 1ns/10ps
module host_cfg_model (
    // Clock
    input  wire logic                 mclk,
    // Configuration access
    output bridge_diag_pkg::cfg_req_t cfg_req,
    input  wire logic                 cfg_ack,
    input  wire logic [31:0]          cfg_rdata
);
    initial cfg_req = '0;

    // One-cycle request; released fields are inverted so stale values never match
    task automatic xfer(input logic wr, input logic [7:0] off, input logic [3:0] be,
                        input logic [31:0] wd, output logic [31:0] rd, output logic ok);
        int n;
        n = 0;
        @(negedge mclk);
        cfg_req = '{valid: 1'b1, write: wr, offset: off, byte_en: be,
                    wdata: wd & 32'hFFFF_FFFD};
        @(negedge mclk);
        cfg_req = {1'b0, ~cfg_req[44:0]};
        while (cfg_ack !== 1'b1 && n < 4) begin
            @(negedge mclk);
            n++;
        end
        rd = cfg_rdata;
        ok = (cfg_ack === 1'b1);
    endtask
endmodule // host_cfg_model

// ===== tb/tb.sv
// Self-checking bench for the control and diagnostic register
`timescale 1ns/10ps
module tb;
    typedef struct packed { logic [31:0] wdata; logic [31:0] exp_v; } row_t;
    localparam row_t ROWS [5] = '{'{32'hFFFF_FFFF, 32'h0007_CDFC},
        '{32'h0000_0000, 32'h0000_0000}, '{32'h0000_0AAA, 32'h0000_08A8},
        '{32'h0005_4555, 32'h0005_4554}, '{32'h0002_8000, 32'h0002_8000}};
    logic                       mclk, rst, global_reset_n, fundamental_reset_n;
    bridge_diag_pkg::cfg_req_t  cfg_req;
    logic                       cfg_ack, power_event_signal, bridge_wake_input;
    logic [31:0]                cfg_rdata, rd;
    bridge_diag_pkg::capture_t  capture;
    logic                       controller_wake_pin, force_read_multiple;
    logic                       read_prefetch_disable, memory_read_multiple;
    logic [7:0]                 cache_line_size, free_buffer_dw, need;
    logic                       cache_line_valid, pci_request, alternate_error_method;
    logic [1:0]                 fifo_size;
    logic                       config_any_function_enable, posted_write_credit_return;
    logic                       completion_credit_return, use_cache_line_size;
    bridge_diag_pkg::prefetch_t prefetch_depth, e_pf;
    logic                       threshold_mode, pci_accept, config_mem_access_enable;
    int                         n_fail, compares;

    bridge_control_diag_reg0 dut_u (.mclk(mclk), .rst(rst), .global_reset_n(global_reset_n),
        .fundamental_reset_n(fundamental_reset_n), .cfg_req(cfg_req), .cfg_ack(cfg_ack),
        .cfg_rdata(cfg_rdata), .capture(capture), .power_event_signal(power_event_signal),
        .bridge_wake_input(bridge_wake_input), .controller_wake_pin(controller_wake_pin),
        .force_read_multiple(force_read_multiple),
        .read_prefetch_disable(read_prefetch_disable),
        .memory_read_multiple(memory_read_multiple), .cache_line_size(cache_line_size),
        .cache_line_valid(cache_line_valid), .free_buffer_dw(free_buffer_dw),
        .pci_request(pci_request), .alternate_error_method(alternate_error_method),
        .fifo_size(fifo_size), .config_any_function_enable(config_any_function_enable),
        .posted_write_credit_return(posted_write_credit_return),
        .completion_credit_return(completion_credit_return),
        .use_cache_line_size(use_cache_line_size), .prefetch_depth(prefetch_depth),
        .threshold_mode(threshold_mode), .pci_accept(pci_accept),
        .config_mem_access_enable(config_mem_access_enable));

    host_cfg_model host_u (.mclk(mclk), .cfg_req(cfg_req), .cfg_ack(cfg_ack),
        .cfg_rdata(cfg_rdata));

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // A lost acknowledge ends the run at once
    task automatic acc(input logic wr, input logic [7:0] off, input logic [3:0] be,
                       input logic [31:0] wd);
        logic ok;
        host_u.xfer(wr, off, be, wd, rd, ok);
        if (!ok) begin
            n_fail++;
            results();
        end
    endtask

    task automatic steer(input logic [31:0] e);
        check({21'h0, alternate_error_method, fifo_size, config_any_function_enable,
            posted_write_credit_return, completion_credit_return, use_cache_line_size,
            threshold_mode, config_mem_access_enable, bridge_wake_input, controller_wake_pin},
            {21'h0, e[18], e[15:14], e[11], e[10], e[8], e[7], e[3], e[2], ~e[17], ~e[16]});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst, global_reset_n, fundamental_reset_n, power_event_signal} = 4'hF;
        {force_read_multiple, read_prefetch_disable, memory_read_multiple} = 3'h0;
        {cache_line_valid, pci_request, cache_line_size, free_buffer_dw} = 18'h0;
        capture = '0;
        n_fail = 0;
        compares = 0;
        repeat (5) @(negedge mclk);
        rst = 1'b0;
        acc(1'b0, 8'hC0, 4'hF, 32'h0);
        check(rd, 32'h0000_0000);
        foreach (ROWS[i]) begin
            acc(1'b1, 8'hC0, 4'hF, ROWS[i].wdata);
            acc(1'b0, 8'hC0, 4'hF, 32'h0);
            check(rd, ROWS[i].exp_v);
            steer(ROWS[i].exp_v);
        end
        // Partial byte write, then an unmapped offset that must not alias
        acc(1'b1, 8'hC0, 4'h2, 32'hFFFF_FFFF);
        acc(1'b1, 8'hC4, 4'hF, 32'hFFFF_FFFF);
        acc(1'b0, 8'hC4, 4'hF, 32'h0);
        check(rd, 32'h0000_0000);
        acc(1'b0, 8'hC0, 4'hF, 32'h0);
        check(rd, 32'h0002_CD00);
        capture = '{bus: 8'hA5, device: 5'h13, valid: 1'b1};
        @(negedge mclk);
        capture.valid = 1'b0;
        acc(1'b1, 8'hC0, 4'hF, 32'h0);
        acc(1'b1, 8'hC0, 4'hF, 32'hFFFF_FFFF);
        acc(1'b0, 8'hC0, 4'hF, 32'h0);
        check(rd, 32'hA59F_CDFC);
        fundamental_reset_n = 1'b0;
        @(negedge mclk);
        fundamental_reset_n = 1'b1;
        acc(1'b0, 8'hC0, 4'hF, 32'h0);
        check(rd, 32'h0003_0000);
        {global_reset_n, fundamental_reset_n} = 2'b00;
        @(negedge mclk);
        {global_reset_n, fundamental_reset_n} = 2'b11;
        acc(1'b0, 8'hC0, 4'hF, 32'h0);
        check(rd, 32'h0000_0000);
        // Threshold edge: one DW short refused, exact space accepted
        cache_line_size = 8'h10;
        pci_request = 1'b1;
        for (int t = 0; t < 4; t++) begin
            acc(1'b1, 8'hC0, 4'hF, {26'h0, 2'(t), 4'h8});
            for (int v = 0; v < 2; v++) begin
                cache_line_valid = 1'(v);
                need = (v == 1) ? 8'h10 : 8'h08;
                need = (t == 3) ? 8'(2 * need + 4) : 8'(need + 4 * (t + 1));
                for (int d = 0; d < 2; d++) begin
                    free_buffer_dw = 8'(need - 1 + d);
                    repeat (2) @(negedge mclk);
                    check({31'h0, pci_accept}, {31'h0, 1'(d)});
                end
            end
        end
        // Threshold mode off: any free space accepts, none refuses
        acc(1'b1, 8'hC0, 4'hF, 32'h0);
        for (int d = 0; d < 2; d++) begin
            free_buffer_dw = 8'(d);
            repeat (2) @(negedge mclk);
            check({31'h0, pci_accept}, {31'h0, 1'(d)});
        end
        pci_request = 1'b0;
        repeat (2) @(negedge mclk);
        check({31'h0, pci_accept}, 32'h0);
        for (int c = 0; c < 4; c++) begin
            acc(1'b1, 8'hC0, 4'hF, {24'h0, 2'(c), 6'h0});
            for (int k = 0; k < 8; k++) begin
                {memory_read_multiple, force_read_multiple, read_prefetch_disable} = 3'(k);
                e_pf = (k % 2 == 1) ? bridge_diag_pkg::PF_ONE_DW :
                       (c == 3 && k >= 2) ? bridge_diag_pkg::PF_FOUR_LINES :
                       bridge_diag_pkg::PF_TWO_LINES;
                repeat (2) @(negedge mclk);
                check({30'h0, prefetch_depth}, {30'h0, e_pf});
            end
        end
        // Wake outputs drop with the event; power-on reset restores defaults
        power_event_signal = 1'b0;
        repeat (2) @(negedge mclk);
        check({30'h0, bridge_wake_input, controller_wake_pin}, 32'h0);
        power_event_signal = 1'b1;
        acc(1'b1, 8'hC0, 4'hF, 32'hFFFF_FFFF);
        rst = 1'b1;
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        acc(1'b0, 8'hC0, 4'hF, 32'h0);
        check(rd, 32'h0000_0000);
        steer(32'h0000_0000);
        results();
    end
endmodule // tb
